// ---- logic/port_io_map.svh ----
/*
 File: register offsets, page codes, field positions and reset values
 for the port pin block.
 Assumes: included by bare name; definitions only.
*/
`ifndef PORT_IO_MAP_SVH
`define PORT_IO_MAP_SVH

// Register page that holds the upper ports and the mode registers
`define PAGE_UPPER        8'h0f

// Port data latches
`define OFS_PORT0_LATCH   8'h80
`define OFS_PORT1_LATCH   8'h90
`define OFS_PORT2_LATCH   8'ha0
`define OFS_PORT3_LATCH   8'hb0
`define OFS_PORT4_LATCH   8'hc8
`define OFS_PORT5_LATCH   8'hd8
`define OFS_PORT6_LATCH   8'he8
`define OFS_PORT7_LATCH   8'hf8

// Drive type registers
`define OFS_PORT0_DRIVE   8'ha4
`define OFS_PORT1_DRIVE   8'ha5
`define OFS_PORT2_DRIVE   8'ha6
`define OFS_PORT3_DRIVE   8'ha7
`define OFS_PORT4_DRIVE   8'h9c
`define OFS_PORT5_DRIVE   8'h9d
`define OFS_PORT6_DRIVE   8'h9e
`define OFS_PORT7_DRIVE   8'h9f

// Input mode of the second port and routing config c
`define OFS_PORT1_INSEL   8'had
`define OFS_ROUTE_C       8'he3

// Fields of routing_config_c
`define BIT_PULLUP_DIS    7
`define BIT_ROUTE_EN      6

// Reset values
`define RST_LATCH         8'hff
`define RST_DRIVE         8'h00
`define RST_INSEL         8'hff
`define RST_ROUTE_C       8'h00

`endif

// ---- logic/port_io_pkg.sv ----
/*
 File: types shared by the port pin block.
 Assumes: compiled before the block.
*/
package port_io_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [2:0] {
      K_NONE, K_LATCH, K_DRIVE, K_INSEL, K_ROUTE
   } reg_kind_t;
   typedef struct packed {
      reg_kind_t   kind;
      logic [2:0]  idx;
   } reg_sel_t;
endpackage : port_io_pkg

// ---- logic/port_io.sv ----
/*
 File: port pin logic for eight 8-bit ports: latches, drive types,
 analog select of port 1, routing gate, external memory takeover,
 synchronised pin read back, register access on the core's bus.
 Assumes: page select register and routing priority live outside;
 pin pads resolve PIN_OUT / PIN_OE_N / PIN_PULLUP into the wire.
*/
// Functional notes
// - Drive type bit 0 gives open-drain, 1 gives push-pull.
// - Push-pull drives low for latch 0, high for latch 1.
// - Open-drain drives low for latch 0, releases for latch 1.
// - Serial data, clock and mode-0 receive pins always open-drain; here only while PERIPH_FORCE_OD is set on the claimed pin.
// - Data writes update latch; pins follow as routing allows.
// - Ordinary reads return pin level, even when routing claims it.
// - Read-modify-write read phase returns latch contents.
// - Port 1 analog pin: no input path, no pullup, reads 0.
// - Port 1 digital pin reads level; pullup follows global disable.
// - Port 1 analog pins are skipped by peripheral routing.
// - Port 1 analog pin drive still follows latch and drive type.
// - Memory port drives ports 1-3 per multiplexed mode.
// - Ports 4-7 latches accept byte and bit access.
// - Drive type registers reset to zero, all open-drain.
// - Each drive type bit controls only its own pin.
// - Unbonded ports keep registers and active inputs.
// - Port 1 input mode register resets to all ones.
// - Pullup disable bit global; pullup off on pins driving 0.
// - Routing disabled forces ports 0-3 to input.
`timescale 1ns/10ps
module port_io (
   input  wire logic                 CLK,
   input  wire logic                 RST,
   input  wire logic [7:0]           SFR_ADDR,
   input  wire logic [7:0]           SFR_PAGE,
   input  wire logic                 SFR_WR,
   input  wire logic                 SFR_RD,
   input  wire logic                 SFR_RMW,
   input  wire logic                 SFR_BIT,
   input  wire logic [2:0]           SFR_BITSEL,
   input  wire port_io_pkg::byte_t   SFR_WDATA,
   output port_io_pkg::byte_t        SFR_RDATA,
   input  wire logic [31:0]          PERIPH_SEL,
   input  wire logic [31:0]          PERIPH_OUT,
   input  wire logic [31:0]          PERIPH_FORCE_OD,
   input  wire logic                 EXTERNAL_MEMORY_PORT_ACTIVE,
   input  wire logic                 EXTERNAL_MEMORY_PORT_MUXED,
   input  wire logic [15:0]          EXTERNAL_MEMORY_PORT_ADDR,
   input  wire logic [7:0]           EXTERNAL_MEMORY_PORT_BUS_OUT,
   input  wire logic                 EXTERNAL_MEMORY_PORT_BUS_DRIVE,
   input  wire logic [63:0]          PIN_IN,
   output logic [63:0]               PIN_OUT,
   output logic [63:0]               PIN_OE_N,
   output logic [63:0]               PIN_PULLUP,
   output logic [7:0]                ROUTE_SKIP,
   output logic                      ROUTE_ENABLE
);
   import port_io_pkg::*;
`include "port_io_map.svh"

   ////////////////////////////////////////////////////////////////////
   // Address decode, shared by write and read paths
   function automatic reg_sel_t decode(input logic [7:0] a,
                                       input logic [7:0] pg);
      reg_sel_t s;
      logic     up;
      s.kind = K_NONE;
      s.idx  = 3'h0;
      up     = (pg == `PAGE_UPPER);
      case (a)
         `OFS_PORT0_LATCH: s = '{K_LATCH, 3'h0};
         `OFS_PORT1_LATCH: s = '{K_LATCH, 3'h1};
         `OFS_PORT2_LATCH: s = '{K_LATCH, 3'h2};
         `OFS_PORT3_LATCH: s = '{K_LATCH, 3'h3};
         `OFS_PORT4_LATCH: if (up) s = '{K_LATCH, 3'h4};
         `OFS_PORT5_LATCH: if (up) s = '{K_LATCH, 3'h5};
         `OFS_PORT6_LATCH: if (up) s = '{K_LATCH, 3'h6};
         `OFS_PORT7_LATCH: if (up) s = '{K_LATCH, 3'h7};
         `OFS_PORT0_DRIVE: if (up) s = '{K_DRIVE, 3'h0};
         `OFS_PORT1_DRIVE: if (up) s = '{K_DRIVE, 3'h1};
         `OFS_PORT2_DRIVE: if (up) s = '{K_DRIVE, 3'h2};
         `OFS_PORT3_DRIVE: if (up) s = '{K_DRIVE, 3'h3};
         `OFS_PORT4_DRIVE: if (up) s = '{K_DRIVE, 3'h4};
         `OFS_PORT5_DRIVE: if (up) s = '{K_DRIVE, 3'h5};
         `OFS_PORT6_DRIVE: if (up) s = '{K_DRIVE, 3'h6};
         `OFS_PORT7_DRIVE: if (up) s = '{K_DRIVE, 3'h7};
         `OFS_PORT1_INSEL: if (up) s = '{K_INSEL, 3'h0};
         `OFS_ROUTE_C:     if (up) s = '{K_ROUTE, 3'h0};
         default:          s = '{K_NONE, 3'h0};
      endcase
      return s;
   endfunction : decode

   // Byte write or single bit write into an old value
   function automatic byte_t merge(input byte_t old);
      byte_t n;
      n = old;
      if (SFR_BIT) begin
         n[SFR_BITSEL] = SFR_WDATA[0];
      end else begin
         n = SFR_WDATA;
      end
      return n;
   endfunction : merge

   reg_sel_t    wsel;
   reg_sel_t    rsel;
   byte_t       latch [8];
   byte_t       drive_type [8];
   byte_t       insel;
   byte_t       route_c;
   logic [63:0] sync1;
   logic [63:0] sync2;
   logic [63:0] next_out;
   logic [63:0] next_oe_n;
   logic [63:0] next_pullup;
   logic        route_en;
   logic        pud;

   assign wsel     = decode(SFR_ADDR, SFR_PAGE);
   assign rsel     = wsel;
   assign route_en = route_c[`BIT_ROUTE_EN];
   assign pud      = route_c[`BIT_PULLUP_DIS];

   ////////////////////////////////////////////////////////////////////
   // Latches and drive type registers
   for (genvar p = 0; p < 8; p++) begin : g_port
      always_ff @(posedge CLK or posedge RST) begin
         if (RST) begin
            latch[p] <= `RST_LATCH;
         end else if (SFR_WR && wsel.kind == K_LATCH &&
                      wsel.idx == 3'(p)) begin
            latch[p] <= merge(latch[p]);
         end
      end
      always_ff @(posedge CLK or posedge RST) begin
         if (RST) begin
            drive_type[p] <= `RST_DRIVE;
         end else if (SFR_WR && wsel.kind == K_DRIVE &&
                      wsel.idx == 3'(p)) begin
            drive_type[p] <= merge(drive_type[p]);
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         insel <= `RST_INSEL;
      end else if (SFR_WR && wsel.kind == K_INSEL) begin
         insel <= merge(insel);
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         route_c <= `RST_ROUTE_C;
      end else if (SFR_WR && wsel.kind == K_ROUTE) begin
         route_c <= merge(route_c);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pin synchroniser; unbonded pins stay live as inputs
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         sync1 <= 64'h0;
         sync2 <= 64'h0;
      end else begin
         sync1 <= PIN_IN;
         sync2 <= sync1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Per-pin drive decision
   for (genvar n = 0; n < 64; n++) begin : g_pin
      localparam int P = n / 8;
      localparam int B = n % 8;
      logic analog;
      logic claimed;
      logic external_memory_port;
      logic external_memory_port_val;
      logic val;
      logic od;
      logic forced_in;
      logic drive;
      always_comb begin
         analog    = (P == 1) && !insel[B];
         claimed   = 1'b0;
         if (P < 4) begin
            claimed = route_en && PERIPH_SEL[n] && !analog;
         end
         external_memory_port      = 1'b0;
         external_memory_port_val  = 1'b0;
         if (EXTERNAL_MEMORY_PORT_ACTIVE) begin
            if (P == 1 && !EXTERNAL_MEMORY_PORT_MUXED) begin
               external_memory_port     = 1'b1;
               external_memory_port_val = EXTERNAL_MEMORY_PORT_ADDR[8 + B];
            end else if (P == 2) begin
               external_memory_port     = 1'b1;
               external_memory_port_val = EXTERNAL_MEMORY_PORT_MUXED ? EXTERNAL_MEMORY_PORT_ADDR[8 + B] : EXTERNAL_MEMORY_PORT_ADDR[B];
            end else if (P == 3) begin
               external_memory_port     = 1'b1;
               external_memory_port_val = EXTERNAL_MEMORY_PORT_BUS_OUT[B];
            end
         end
         val = external_memory_port ? external_memory_port_val : (claimed ? PERIPH_OUT[n] : latch[P][B]);
         od  = !drive_type[P][B];
         if (claimed && PERIPH_FORCE_OD[n]) begin
            od = 1'b1;
         end
         forced_in = (P < 4) && !route_en;
         // A memory read turns the data bus drivers off
         if (P == 3 && EXTERNAL_MEMORY_PORT_ACTIVE && !EXTERNAL_MEMORY_PORT_BUS_DRIVE) begin
            forced_in = 1'b1;
         end
         drive          = !forced_in && (!val || !od);
         next_out[n]    = val;
         next_oe_n[n]   = !drive;
         next_pullup[n] = !pud && !analog && !(drive && !val);
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         PIN_OUT    <= {64{1'b1}};
         PIN_OE_N   <= {64{1'b1}};
         PIN_PULLUP <= 64'h0;
      end else begin
         PIN_OUT    <= next_out;
         PIN_OE_N   <= next_oe_n;
         PIN_PULLUP <= next_pullup;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ROUTE_SKIP   <= 8'h00;
         ROUTE_ENABLE <= 1'b0;
      end else begin
         ROUTE_SKIP   <= ~insel;
         ROUTE_ENABLE <= route_en;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read path; one cycle from strobe to data
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         SFR_RDATA <= 8'h00;
      end else if (SFR_RD) begin
         case (rsel.kind)
            K_LATCH: begin
               if (SFR_RMW) begin
                  SFR_RDATA <= latch[rsel.idx];
               end else if (rsel.idx == 3'h1) begin
                  SFR_RDATA <= sync2[15:8] & insel;
               end else begin
                  SFR_RDATA <= sync2[8*rsel.idx +: 8];
               end
            end
            K_DRIVE: SFR_RDATA <= drive_type[rsel.idx];
            K_INSEL: SFR_RDATA <= insel;
            K_ROUTE: SFR_RDATA <= route_c;
            default: SFR_RDATA <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   sequence s_plain_read(logic [7:0] a);
      SFR_RD && !SFR_RMW && SFR_ADDR == a;
   endsequence

   a_push_high: assert property (
      drive_type[4][3] && latch[4][3] |=> !PIN_OE_N[35] && PIN_OUT[35])
      else $error("push-pull pin not driven high");
   a_open_release: assert property (
      !drive_type[4][0] && latch[4][0] |=> PIN_OE_N[32])
      else $error("open-drain pin not released");
   a_drive_low: assert property (
      !latch[4][1] |=> !PIN_OE_N[33] && !PIN_OUT[33] && !PIN_PULLUP[33])
      else $error("latch zero not driven low");
   a_force_input: assert property (
      !route_en && !EXTERNAL_MEMORY_PORT_ACTIVE |=> PIN_OE_N[31:0] == 32'hffffffff)
      else $error("disabled routing left a driver on");
   a_serial_od: assert property (
      route_en && PERIPH_SEL[0] && PERIPH_FORCE_OD[0] && PERIPH_OUT[0]
      |=> PIN_OE_N[0])
      else $error("forced open-drain pin drove high");
   a_latch_write: assert property (
      SFR_WR && !SFR_BIT && SFR_ADDR == `OFS_PORT4_LATCH &&
      SFR_PAGE == `PAGE_UPPER |=> latch[4] == $past(SFR_WDATA))
      else $error("upper port latch not written");
   a_page_gate: assert property (
      SFR_WR && SFR_ADDR == `OFS_PORT5_LATCH && SFR_PAGE != `PAGE_UPPER
      |=> $stable(latch[5]))
      else $error("upper port written off page");
   a_pin_read: assert property (
      s_plain_read(`OFS_PORT0_LATCH) |=> SFR_RDATA == $past(sync2[7:0]))
      else $error("read did not return pin level");
   a_rmw_read: assert property (
      SFR_RD && SFR_RMW && SFR_ADDR == `OFS_PORT3_LATCH
      |=> SFR_RDATA == $past(latch[3]))
      else $error("read-modify-write did not return latch");
   a_analog_zero: assert property (
      s_plain_read(`OFS_PORT1_LATCH)
      |=> (SFR_RDATA & ~$past(insel)) == 8'h00)
      else $error("analog pin read not zero");
   a_sync_depth: assert property (
      s_plain_read(`OFS_PORT0_LATCH) |=> SFR_RDATA == $past(PIN_IN[7:0], 3))
      else $error("pin read not two stages deep");
endmodule : port_io

// ---- tb/pin_board.sv ----
/*
 File: board model around the port pins; resolves each pin level.
 Assumes: driver enables are active low; floating pins toggle.
*/
`timescale 1ns/10ps
module pin_board (
   input  wire logic        clk,
   input  wire logic [63:0] pin_out,
   input  wire logic [63:0] pin_oe_n,
   input  wire logic [63:0] pin_pullup,
   input  wire logic [63:0] ext_drv,
   input  wire logic [63:0] ext_val,
   output logic [63:0]      pin_in
);
   logic flip;
   ////////////////////////////////////////////////////////////////////
   // A floating pin must not look like a stable level
   initial flip = 1'b0;
   always @(posedge clk) begin
      flip <= ~flip;
   end
   always_comb begin
      for (int i = 0; i < 64; i++) begin
         if (!pin_oe_n[i]) begin
            pin_in[i] = pin_out[i];
         end else if (ext_drv[i]) begin
            pin_in[i] = ext_val[i];
         end else if (pin_pullup[i]) begin
            pin_in[i] = 1'b1;
         end else begin
            pin_in[i] = flip;
         end
      end
   end
endmodule : pin_board

// ---- tb/port_io_tb_top.sv ----
/*
 File: self-checking bench for the port pin block.
 Assumes: register map header and package compiled; board model.
*/
`timescale 1ns/10ps
`include "port_io_map.svh"
module port_io_tb_top;
   import port_io_pkg::*;
   localparam byte_t pu = `PAGE_UPPER;
   logic        clk, rst, wr, rd, rmw, bt;
   logic [2:0]  bs;
   byte_t       addr, page, wd, rdata, eb;
   logic [31:0] psel, pout, pod;
   logic        ea, em, ed;
   logic [15:0] ead;
   logic [63:0] pin_in, pout_w, oe_n, pup, xd, xv;
   logic [7:0]  skip;
   logic        ren;
   int          fails, cmp_count;
   ////////////////////////////////////////////////////////////////////
   port_io u_port_io (.CLK(clk), .RST(rst), .SFR_ADDR(addr),
      .SFR_PAGE(page), .SFR_WR(wr), .SFR_RD(rd), .SFR_RMW(rmw),
      .SFR_BIT(bt), .SFR_BITSEL(bs), .SFR_WDATA(wd),
      .SFR_RDATA(rdata), .PERIPH_SEL(psel), .PERIPH_OUT(pout),
      .PERIPH_FORCE_OD(pod), .EXTERNAL_MEMORY_PORT_ACTIVE(ea), .EXTERNAL_MEMORY_PORT_MUXED(em),
      .EXTERNAL_MEMORY_PORT_ADDR(ead), .EXTERNAL_MEMORY_PORT_BUS_OUT(eb), .EXTERNAL_MEMORY_PORT_BUS_DRIVE(ed),
      .PIN_IN(pin_in), .PIN_OUT(pout_w), .PIN_OE_N(oe_n),
      .PIN_PULLUP(pup), .ROUTE_SKIP(skip), .ROUTE_ENABLE(ren));
   pin_board u_pin_board (.clk(clk), .pin_out(pout_w),
      .pin_oe_n(oe_n), .pin_pullup(pup), .ext_drv(xd),
      .ext_val(xv), .pin_in(pin_in));
   ////////////////////////////////////////////////////////////////////
   task chk(input string n, input logic [63:0] e, input logic [63:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task end_sim;
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim
   // Bit writes carry the new bit value in data bit 0
   task wrt(input byte_t p, a, d, input logic b, input logic [2:0] s);
      @(posedge clk);
      {page, addr, wd, bt, bs, wr} <= {p, a, d, b, s, 1'b1};
      @(posedge clk);
      {wr, bt} <= 2'b00;
   endtask : wrt
   task rdc(input byte_t p, a, input logic m, input byte_t e);
      @(posedge clk);
      {page, addr, rmw, rd} <= {p, a, m, 1'b1};
      @(posedge clk);
      {rd, rmw} <= 2'b00;
      #1;
      chk("rdata", e, rdata);
   endtask : rdc
   // Two sync stages plus the output register, with margin
   task settle;
      repeat (4) @(posedge clk);
      #1;
   endtask : settle
   ////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      end_sim();
   end
   initial begin
      {rst, wr, rd, rmw, bt, bs, addr, page, wd} = {1'b1, 31'h0};
      {psel, pout, pod, ea, em, ed, ead, eb} = 123'h0;
      {xd, xv} = 128'h0;
      fails = 0;
      cmp_count = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         rdc(pu, `OFS_PORT0_DRIVE + i[7:0], 1'b0, 8'h00);
         rdc(pu, `OFS_PORT4_DRIVE + i[7:0], 1'b0, 8'h00);
      end
      rdc(pu, `OFS_PORT1_INSEL, 1'b0, 8'hff);
      rdc(8'h00, `OFS_PORT0_LATCH, 1'b0, 8'hff);
      rdc(8'h00, `OFS_PORT3_LATCH, 1'b1, 8'hff);
      // Routing off: port 2 latch 0 must not drive
      wrt(8'h00, `OFS_PORT2_LATCH, 8'h00, 1'b0, 3'd0);
      settle();
      chk("oe2 off", 64'hff, oe_n[23:16]);
      wrt(pu, `OFS_ROUTE_C, 8'h40, 1'b0, 3'd0);
      settle();
      chk("route en", 64'h1, ren);
      rdc(pu, `OFS_ROUTE_C, 1'b0, 8'h40);
      chk("oe2 on", 64'h00, oe_n[23:16]);
      // Port 4: only pin 3 push-pull
      wrt(pu, `OFS_PORT4_DRIVE, 8'h08, 1'b0, 3'd0);
      wrt(pu, `OFS_PORT4_LATCH, 8'h00, 1'b0, 3'd0);
      settle();
      chk("oe4 low", 64'h00, oe_n[39:32]);
      chk("out4 low", 64'h00, pout_w[39:32]);
      chk("pu4 low", 64'h00, pup[39:32]);
      wrt(pu, `OFS_PORT4_LATCH, 8'hff, 1'b0, 3'd0);
      {xd[39:32], xv[39:32]} <= 16'hff5a;
      settle();
      chk("oe4 high", 64'hf7, oe_n[39:32]);
      chk("out43", 64'h1, pout_w[35]);
      chk("pu4 od", 64'hf7, pup[39:32] & 8'hf7);
      rdc(pu, `OFS_PORT4_LATCH, 1'b0, 8'h5a);
      rdc(pu, `OFS_PORT4_LATCH, 1'b1, 8'hff);
      rdc(8'h00, `OFS_PORT4_LATCH, 1'b0, 8'h00);
      wrt(8'h00, `OFS_PORT5_LATCH, 8'h00, 1'b0, 3'd0);
      rdc(pu, `OFS_PORT5_LATCH, 1'b1, 8'hff);
      wrt(pu, `OFS_PORT4_LATCH, 8'h00, 1'b1, 3'd6);
      settle();
      rdc(pu, `OFS_PORT4_LATCH, 1'b1, 8'hbf);
      rdc(pu, `OFS_PORT4_LATCH, 1'b0, 8'h1a);
      // Port 1 pin 0 analog
      {xd[15:8], xv[15:8]} <= 16'hffff;
      wrt(pu, `OFS_PORT1_INSEL, 8'hfe, 1'b0, 3'd0);
      settle();
      rdc(8'h00, `OFS_PORT1_LATCH, 1'b0, 8'hfe);
      chk("pu1", 64'hfe, pup[15:8]);
      chk("skip", 64'h01, skip);
      wrt(8'h00, `OFS_PORT1_LATCH, 8'hfe, 1'b0, 3'd0);
      settle();
      chk("oe1 analog", 64'h0, oe_n[8]);
      wrt(pu, `OFS_ROUTE_C, 8'hc0, 1'b0, 3'd0);
      settle();
      chk("pu off", 64'h0, pup);
      wrt(pu, `OFS_ROUTE_C, 8'h40, 1'b0, 3'd0);
      wrt(pu, `OFS_PORT1_INSEL, 8'hff, 1'b0, 3'd0);
      // Claimed serial pin open-drain while forced, push-pull once force drops
      wrt(pu, `OFS_PORT0_DRIVE, 8'h01, 1'b0, 3'd0);
      {psel[0], pout[0], pod[0]} <= 3'b111;
      settle();
      chk("od forced", 64'h1, oe_n[0]);
      @(posedge clk);
      pod[0] <= 1'b0;
      settle();
      chk("pp claimed", 64'h0, {oe_n[0], ~pout_w[0]});
      // Claimed pin low while its latch stays high
      @(posedge clk);
      pout[0] <= 1'b0;
      settle();
      rdc(8'h00, `OFS_PORT0_LATCH, 1'b0, 8'hfe);
      rdc(8'h00, `OFS_PORT0_LATCH, 1'b1, 8'hff);
      // Memory port takeover
      for (int i = 1; i < 4; i++) begin
         wrt(pu, `OFS_PORT0_DRIVE + i[7:0], 8'hff, 1'b0, 3'd0);
      end
      {ea, em, ed, ead, eb} <= {3'b111, 16'hab12, 8'h3c};
      settle();
      chk("mux p2p3", 64'h3cab, pout_w[31:16]);
      chk("mux oe", 64'h0, oe_n[31:16]);
      @(posedge clk);
      em <= 1'b0;
      settle();
      chk("nmux p1p2", 64'h12ab, pout_w[23:8]);
      @(posedge clk);
      ed <= 1'b0;
      settle();
      chk("bus off", 64'hff, oe_n[31:24]);
      end_sim();
   end
endmodule : port_io_tb_top
